// ---- test/two_wire_master_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module two_wire_master_model (
    output logic      scl,     // serial clock, parked high
    output logic      sdaDrv,  // 0 pulls data low, 1 releases
    input  wire logic sdaLine  // resolved data line
);
    // idle link: both lines released, clock stands still
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    // start or repeated start: data falls while clock high
    task startCond;
        #300 sdaDrv = 1'b1;
        #100 scl = 1'b1;
        #200 sdaDrv = 1'b0;
        #200 scl = 1'b0;
    endtask : startCond
    // stop: data rises while clock high, link left idle
    task stopCond;
        #300 sdaDrv = 1'b0;
        #100 scl = 1'b1;
        #200 sdaDrv = 1'b1;
        #200;
    endtask : stopCond
    // data moves 300 ns after clock fall so the synced slave has seen it
    task bitIo(input logic b, output logic r);
        #300 sdaDrv = b;
        #100 scl = 1'b1;
        #200 r = sdaLine;
        #200 scl = 1'b0;
    endtask : bitIo
    // eight bits msb first, then the ack slot; send 8'hff to read
    task byteIo(input logic [7:0] tx, input logic ackTx, output logic [7:0] rx, output logic ackRx);
        for (int i = 7; i >= 0; i--) begin
            bitIo(tx[i], rx[i]);
        end
        bitIo(ackTx, ackRx);
    endtask : byteIo
endmodule : two_wire_master_model
`default_nettype wire

// ---- test/two_wire_register_slave_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module two_wire_register_slave_assertions (
    input wire logic                          sys_clk,       // system clock
    input wire logic                          resetn,        // sync reset, active low
    input wire logic                          clkEn,         // clock enable
    input wire logic                          serialClock,   // serial clock pin
    input wire logic                          serialDataIn,  // resolved data line
    input wire logic                          serialDataOut, // data drive value
    input wire logic                          serialDataOeN, // low while pulling low
    input wire logic                          busAddrSelect, // address select pin
    input wire two_wire_slave_pkg::reg_write_t wrReq,        // word write
    input wire logic                          wrValid,       // write strobe
    input wire logic [15:0]                   rdAddr,        // word read address
    input wire logic [15:0]                   rdData         // register contents
);
    import two_wire_slave_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // clock parked high a full bit period only happens between frames
    sequence clockParked;
        serialClock[*8];
    endsequence
    // ack drive lands with the write strobe or one cycle later
    sequence ackDriven;
        ##[0:1] !serialDataOeN;
    endsequence

    // pin behaviour; a change while the clock is high would fake start or stop
    chk_drive_zero: assert property (serialDataOut == 1'b0) else $error("drive value not zero");
    chk_no_conditions: assert property (serialClock && $past(serialClock) |-> $stable(serialDataOeN))
        else $error("data drive moved while clock high");
    chk_idle_release: assert property (clockParked |-> serialDataOeN)
        else $error("data line held on idle link");
    // write port
    chk_write_pulse: assert property (wrValid |=> !wrValid) else $error("write strobe too long");
    chk_word_hold: assert property (!wrValid |-> $stable(wrReq)) else $error("write word moved");
    chk_word_even: assert property (wrValid |-> !wrReq.addr[0]) else $error("odd write address");
    chk_write_ack: assert property (wrValid |-> ackDriven) else $error("write not acknowledged");
    // read port
    chk_read_even: assert property (rdAddr[0] == 1'b0) else $error("odd read address");
    chk_pointer_move: assert property ($changed(rdAddr) |-> !serialClock)
        else $error("pointer moved with clock high");
endmodule : two_wire_register_slave_assertions

bind two_wire_register_slave two_wire_register_slave_assertions chk (
    .sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOeN(serialDataOeN),
    .busAddrSelect(busAddrSelect), .wrReq(wrReq), .wrValid(wrValid), .rdAddr(rdAddr), .rdData(rdData));
`default_nettype wire

// ---- test/two_wire_register_slave_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module two_wire_register_slave_tb_top;
    import two_wire_slave_pkg::*;
    logic        sys_clk, resetn, clkEn, busAddrSelect, serialClock, mSda, sdaLine;
    logic        serialDataOut, serialDataOeN, wrValid, ack;
    logic [15:0] rdAddr, rdData;
    logic [7:0]  rx;
    reg_write_t  wrReq, lastWr;
    int          err_total, checks_done, wrCount;

    // open drain: pulled up unless someone pulls low
    assign sdaLine = mSda & (serialDataOeN | serialDataOut);
    // register file stand-in, contents follow the word address
    assign rdData = rdAddr ^ 16'h3C96;

    two_wire_register_slave uut (.sys_clk(sys_clk), .resetn(resetn), .clkEn(clkEn),
        .serialClock(serialClock), .serialDataIn(sdaLine), .serialDataOut(serialDataOut),
        .serialDataOeN(serialDataOeN), .busAddrSelect(busAddrSelect), .wrReq(wrReq),
        .wrValid(wrValid), .rdAddr(rdAddr), .rdData(rdData));
    two_wire_master_model mst (.scl(serialClock), .sdaDrv(mSda), .sdaLine(sdaLine));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // capture every word handed to the register file
    always @(posedge sys_clk) begin
        if (wrValid === 1'b1) begin
            wrCount++;
            lastWr = wrReq;
        end
    end
    ////////////////////////////////////////////////////////////////
    task cmpVal(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmpVal
    task cmpBit(input logic got, input logic exp, input string what);
        cmpVal({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
    endtask : cmpBit
    function automatic logic [7:0] expByte(input logic [15:0] p);
        logic [15:0] w;
        w = {p[15:1], 1'b0} ^ 16'h3C96;
        return p[0] ? w[7:0] : w[15:8];
    endfunction : expByte
    // frames start just after a clock edge so link edges never meet sys_clk edges
    task frameStart(input logic [7:0] a, input logic expAck);
        @(posedge sys_clk);
        #10 mst.startCond();
        mst.byteIo(a, 1'b1, rx, ack);
        cmpBit(ack, expAck, "address ack");
    endtask : frameStart
    task putByte(input logic [7:0] b);
        mst.byteIo(b, 1'b1, rx, ack);
        cmpBit(ack, 1'b0, "data ack");
    endtask : putByte
    task getByte(input logic [7:0] exp, input logic last);
        mst.byteIo(8'hFF, last, rx, ack);
        cmpVal({24'h00_0000, rx}, {24'h00_0000, exp}, "read byte");
    endtask : getByte
    ////////////////////////////////////////////////////////////////
    task testWrite;
        wrCount = 0;
        frameStart(8'h90, 1'b0);
        putByte(8'h12);
        putByte(8'h34);
        putByte(8'hAB);
        putByte(8'hCD);
        mst.stopCond();
        cmpVal(lastWr, 32'h1234_ABCD, "write word");
        cmpVal(wrCount, 32'h0000_0001, "write count");
        $display("write test done");
    endtask : testWrite
    task testSeqWrite;
        wrCount = 0;
        frameStart(8'h90, 1'b0);
        putByte(8'h01);
        putByte(8'h00);
        for (int i = 0; i < 4; i++) begin
            putByte(8'h11 * (i + 1));
        end
        mst.stopCond();
        cmpVal(lastWr, 32'h0102_3344, "second word");
        cmpVal(wrCount, 32'h0000_0002, "word count");
        $display("sequential write test done");
    endtask : testSeqWrite
    task testRandomRead;
        frameStart(8'h90, 1'b0);
        putByte(8'h02);
        putByte(8'h00);
        frameStart(8'h91, 1'b0);
        getByte(expByte(16'h0200), 1'b0);
        getByte(expByte(16'h0201), 1'b1);
        mst.stopCond();
        $display("random read test done");
    endtask : testRandomRead
    task testCurrentRead;
        frameStart(8'h91, 1'b0);
        for (int i = 0; i < 4; i++) begin
            getByte(expByte(16'h0202 + i), i == 3);
        end
        mst.stopCond();
        $display("current read test done");
    endtask : testCurrentRead
    // each select level: foreign address ignored, own read address answered
    task testSelect;
        logic [15:0] ptr;
        ptr = 16'h0206;
        for (int s = 0; s < 2; s++) begin
            @(posedge sys_clk);
            #10 busAddrSelect = s[0];
            frameStart(s ? 8'h90 : 8'hBA, 1'b1);
            mst.byteIo(8'h55, 1'b1, rx, ack);
            cmpBit(ack, 1'b1, "ignored byte");
            mst.stopCond();
            frameStart(s ? 8'hBB : 8'h91, 1'b0);
            getByte(expByte(ptr), 1'b1);
            mst.stopCond();
            ptr = ptr + 16'h0001;
        end
        $display("address select test done");
    endtask : testSelect
    // frozen block must neither answer nor move its pointer; select is still high here
    task testFreeze;
        @(posedge sys_clk);
        #10 clkEn = 1'b0;
        frameStart(8'hBB, 1'b1);
        mst.stopCond();
        @(posedge sys_clk);
        #10 clkEn = 1'b1;
        frameStart(8'hBB, 1'b0);
        getByte(expByte(16'h0208), 1'b1);
        mst.stopCond();
        $display("clock enable test done");
    endtask : testFreeze
    task close_out;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // watchdog: a hung link counts against the run
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("MISMATCH t=%0t run timed out", $time);
        close_out();
    end
    initial begin
        err_total = 0;
        checks_done = 0;
        wrCount = 0;
        resetn = 1'b0;
        clkEn = 1'b1;
        busAddrSelect = 1'b0;
        repeat (5) @(posedge sys_clk);
        #10 resetn = 1'b1;
        repeat (3) @(posedge sys_clk);
        testWrite();
        testSeqWrite();
        testRandomRead();
        testCurrentRead();
        testSelect();
        testFreeze();
        close_out();
    end
endmodule : two_wire_register_slave_tb_top
`default_nettype wire

// ---- verilog/two_wire_register_slave.sv ----
// Behaviour
// - bytes move eight bits, MSB first, each followed by an acknowledge bit
// - one bit per serial clock period; data changes only while clock is low
// - first byte after start: bits 7..1 slave address, bit 0 direction
// - select low answers 0x90/0x91, select high answers 0xBA/0xBB
// - both lines high means idle; start takes the link, stop frees it
// - start is data falling while clock high; repeated start allowed
// - stop is data rising while clock high and ends the transfer
// - transmitter releases data in acknowledge period; receiver drives low to acknowledge
// - acknowledge address byte only on match, otherwise keep line released
// - write carries 16-bit register address, high byte first, each acknowledged
// - then 16-bit write data, high byte first, each acknowledged
// - random read: write address, register address, repeated start, read address
// - single random read returns the 16-bit register as two bytes
// - read without register address uses the retained address
// - sequential read keeps sending bytes while master acknowledges
// - sequential write accepts further data bytes, acknowledging each
`timescale 1ns/100ps
`default_nettype none
module two_wire_register_slave #(
    parameter int SYNC_STAGES = two_wire_slave_pkg::SYNC_STAGES_DEFAULT
) (
    input  wire logic                            sys_clk,        // system clock
    input  wire logic                            resetn,         // synchronous reset, active low
    input  wire logic                            clkEn,          // freezes all state while low
    input  wire logic                            serialClock,    // serial clock pin from master
    input  wire logic                            serialDataIn,   // serial data line level
    output      logic                            serialDataOut,  // serial data drive value
    output      logic                            serialDataOeN,  // low while pulling data line low
    input  wire logic                            busAddrSelect,  // bus address select pin
    output      two_wire_slave_pkg::reg_write_t  wrReq,          // word write address and data
    output      logic                            wrValid,        // one-cycle write strobe
    output      logic [15:0]                     rdAddr,         // word address being read
    input  wire logic [15:0]                     rdData          // register contents at rdAddr
);
    import two_wire_slave_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    // a single stage would let a metastable level reach the edge detectors
    if (SYNC_STAGES < 2) begin : g_bad_sync
        $error("SYNC_STAGES must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNC_STAGES-1:0] sclSync;
    logic [SYNC_STAGES-1:0] sdaSync;
    logic [SYNC_STAGES-1:0] selSync;
    logic                   sclS;
    logic                   sdaS;
    logic                   selS;
    logic                   sclPrev;
    logic                   sdaPrev;

    // reset to the idle level so no false start appears at release
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclSync <= '1;
            sdaSync <= '1;
            selSync <= '0;
        end else if (clkEn) begin
            sclSync <= {sclSync[SYNC_STAGES-2:0], serialClock};
            sdaSync <= {sdaSync[SYNC_STAGES-2:0], serialDataIn};
            selSync <= {selSync[SYNC_STAGES-2:0], busAddrSelect};
        end
    end

    assign sclS = sclSync[SYNC_STAGES-1];
    assign sdaS = sdaSync[SYNC_STAGES-1];
    assign selS = selSync[SYNC_STAGES-1];

    // previous settled levels for edge detection
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (clkEn) begin
            sclPrev <= sclS;
            sdaPrev <= sdaS;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // line events

    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    // data is only sampled on clock rise, changes only go out after a fall
    assign sclRise = sclS & ~sclPrev;
    assign sclFall = ~sclS & sclPrev;
    assign startSeen = sclS & sclPrev & sdaPrev & ~sdaS;
    assign stopSeen = sclS & sclPrev & ~sdaPrev & sdaS;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    link_state_t state;
    logic [2:0]  bitCnt;
    logic [7:0]  shiftReg;
    logic        byteFull;
    logic        isAddr;
    logic        readMode;
    logic [1:0]  msgIdx;
    logic [15:0] pointer;
    logic [7:0]  addrHi;
    logic [7:0]  dataHi;

    link_state_t next_state;
    logic [2:0]  next_bitCnt;
    logic [7:0]  next_shiftReg;
    logic        next_byteFull;
    logic        next_isAddr;
    logic        next_readMode;
    logic [1:0]  next_msgIdx;
    logic [15:0] next_pointer;
    logic [7:0]  next_addrHi;
    logic [7:0]  next_dataHi;
    logic        next_oeN;
    logic        next_wrValid;
    reg_write_t  next_wrReq;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding

    logic [7:0]  ownAddr;
    logic        addrMatch;
    logic [7:0]  txByte;
    logic [15:0] pointerInc;
    logic [15:0] wordAddr;

    assign ownAddr = selS ? BUS_ADDR_ALTERNATE : BUS_ADDR_PRIMARY;
    assign addrMatch = (shiftReg[7:1] == ownAddr[7:1]);
    // register words are byte-addressed, high byte at the even address
    assign wordAddr = {pointer[15:1], 1'b0};
    assign txByte = pointer[0] ? rdData[7:0] : rdData[15:8];
    assign pointerInc = pointer + 16'h0001;
    assign rdAddr = wordAddr;
    // open drain: the line is only ever pulled low
    assign serialDataOut = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // link sequencer

    always_comb begin
        next_state = state;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_byteFull = byteFull;
        next_isAddr = isAddr;
        next_readMode = readMode;
        next_msgIdx = msgIdx;
        next_pointer = pointer;
        next_addrHi = addrHi;
        next_dataHi = dataHi;
        next_oeN = serialDataOeN;
        next_wrValid = 1'b0;
        next_wrReq = wrReq;
        if (stopSeen) begin
            // release everything; the pointer is kept for current reads
            next_state = ST_IDLE;
            next_oeN = 1'b1;
        end else if (startSeen) begin
            // a repeated start also ends a write cleanly here
            next_state = ST_RECV;
            next_isAddr = 1'b1;
            next_bitCnt = FIRST_BIT;
            next_byteFull = 1'b0;
            next_msgIdx = MSG_ADDR_HI;
            next_oeN = 1'b1;
        end else begin
            case (state)
                ST_RECV: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaS};
                        next_bitCnt = bitCnt + 3'h1;
                        if (bitCnt == LAST_BIT) begin
                            next_byteFull = 1'b1;
                        end
                    end else if (sclFall && byteFull) begin
                        next_byteFull = 1'b0;
                        if (isAddr) begin
                            if (addrMatch) begin
                                next_isAddr = 1'b0;
                                next_readMode = shiftReg[DIR_BIT];
                                next_msgIdx = MSG_ADDR_HI;
                                next_oeN = 1'b0;
                                next_state = ST_ACK;
                            end else begin
                                next_state = ST_IDLE;
                            end
                        end else begin
                            next_oeN = 1'b0;
                            next_state = ST_ACK;
                            case (msgIdx)
                                MSG_ADDR_HI: begin
                                    next_addrHi = shiftReg;
                                    next_msgIdx = MSG_ADDR_LO;
                                end
                                MSG_ADDR_LO: begin
                                    next_pointer = {addrHi, shiftReg};
                                    next_msgIdx = MSG_DATA;
                                end
                                default: begin
                                    if (!pointer[0]) begin
                                        next_dataHi = shiftReg;
                                    end else begin
                                        next_wrValid = 1'b1;
                                        next_wrReq.addr = wordAddr;
                                        next_wrReq.data = {dataHi, shiftReg};
                                    end
                                    next_pointer = pointerInc;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    // hold the acknowledge low through the whole high phase
                    if (sclFall) begin
                        next_bitCnt = FIRST_BIT;
                        if (readMode) begin
                            next_shiftReg = txByte;
                            next_oeN = txByte[7];
                            next_state = ST_SEND;
                        end else begin
                            next_oeN = 1'b1;
                            next_state = ST_RECV;
                        end
                    end
                end
                ST_SEND: begin
                    if (sclRise) begin
                        next_bitCnt = bitCnt + 3'h1;
                        if (bitCnt == LAST_BIT) begin
                            next_byteFull = 1'b1;
                        end
                    end else if (sclFall) begin
                        if (byteFull) begin
                            next_byteFull = 1'b0;
                            next_oeN = 1'b1;
                            next_pointer = pointerInc;
                            next_state = ST_MACK;
                        end else begin
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_oeN = shiftReg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (sclRise) begin
                        if (sdaS) begin
                            next_state = ST_IDLE;
                        end else begin
                            next_byteFull = 1'b1;
                        end
                    end else if (sclFall && byteFull) begin
                        next_byteFull = 1'b0;
                        next_bitCnt = FIRST_BIT;
                        next_shiftReg = txByte;
                        next_oeN = txByte[7];
                        next_state = ST_SEND;
                    end
                end
                default: begin
                    // idle or ignoring a transfer meant for another device
                    next_oeN = 1'b1;
                    next_byteFull = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer registers

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= ST_IDLE;
            bitCnt <= FIRST_BIT;
            shiftReg <= BYTE_RESET;
            byteFull <= 1'b0;
            isAddr <= 1'b0;
            readMode <= 1'b0;
            msgIdx <= MSG_ADDR_HI;
        end else if (clkEn) begin
            state <= next_state;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            byteFull <= next_byteFull;
            isAddr <= next_isAddr;
            readMode <= next_readMode;
            msgIdx <= next_msgIdx;
        end
    end

    // address, data and line drive registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pointer <= POINTER_RESET;
            addrHi <= BYTE_RESET;
            dataHi <= BYTE_RESET;
            serialDataOeN <= 1'b1;
            wrValid <= 1'b0;
            wrReq <= '0;
        end else if (clkEn) begin
            pointer <= next_pointer;
            addrHi <= next_addrHi;
            dataHi <= next_dataHi;
            serialDataOeN <= next_oeN;
            wrValid <= next_wrValid;
            wrReq <= next_wrReq;
        end
    end

endmodule : two_wire_register_slave
`default_nettype wire

// ---- verilog/two_wire_slave_pkg.sv ----
`default_nettype none
package two_wire_slave_pkg;

    // write forms of the two selectable bus addresses
    localparam logic [7:0]  BUS_ADDR_PRIMARY = 8'h90;
    localparam logic [7:0]  BUS_ADDR_ALTERNATE = 8'hBA;

    // bit position of the direction flag in the address byte
    localparam int          DIR_BIT = 0;

    // bit counter value of the eighth bit of a byte
    localparam logic [2:0]  LAST_BIT = 3'h7;
    localparam logic [2:0]  FIRST_BIT = 3'h0;

    // values after reset
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;

    // message byte index within a write transfer
    localparam logic [1:0]  MSG_ADDR_HI = 2'h0;
    localparam logic [1:0]  MSG_ADDR_LO = 2'h1;
    localparam logic [1:0]  MSG_DATA = 2'h2;

    // default depth of the pin synchronisers
    localparam int          SYNC_STAGES_DEFAULT = 2;

    // one register word write toward the register file
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } reg_write_t;

    // link sequencing states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK
    } link_state_t;

endpackage : two_wire_slave_pkg
`default_nettype wire
